// [logic/gas_alarm_mode_controller.sv]
// Mode, alarm, lamp, display and loop output control of a gas detector head.
// Overview of operation
// - After power-up run a 25 s initial clear without alarms, then detect.
// - Leaving detection mode while the gas alarm is on clears the alarm.
// - User menu items 1-0 version/checksum, 1-1 zero, 1-2 settings, 1-3 maintenance.
// - User mode returns to detection ten hours after entry; key presses do not restart the timer.
// - Menu-escape key returns from user menu to detection; operator presses it.
// - Zero adjust shows PASS, or FAIL when too far off, keeping item 1-1.
// - Gas alarm rises when concentration is at or above the setpoint.
// - Alarm waits a 2 s delay first; the delay can be disabled.
// - Gas alarm clears by itself once concentration falls below the setpoint.
// - Red alarm lamp lit while the gas alarm is on, not during the delay.
// - Green power lamp stays on while the device operates.
// - Internal abnormality raises fault, lights yellow lamp, shows an error code.
// - When the fault goes away the device restarts with initial clear.
// - Over-temperature alternates display with E-27, loop tracks, fault lamp off.
// - Loop code chosen per state: 4 mA, proportional, 0.5 mA or 20.5 mA.
// - Loop output never exceeds 20.5 mA during over-scale unless inhibit drives a higher code.
// - Alarm test tracks concentration with output on, else holds 4 mA.
// - Inhibit drives the maintenance-configured loop value, default 4.0 mA.
// - Positive readings below the 6 percent threshold display as zero.
// - Suppression is off during zero adjustment.
// - Negatives suppressed to 10 percent; beyond shows -0.0 and blocks detection.
// - Loop self-check shows E-9 when the current is not delivered.
`timescale 1ns/1ns
module gas_alarm_mode_controller #(
    parameter logic [41:0] INIT_CLEAR_CYC = gas_ctl_pkg::INIT_CLEAR_CYC,
    parameter logic [41:0] ALARM_DELAY_CYC = gas_ctl_pkg::ALARM_DELAY_CYC,
    parameter logic [41:0] USER_TIMEOUT_CYC = gas_ctl_pkg::USER_TIMEOUT_CYC,
    parameter logic [41:0] WARN_ALT_CYC = gas_ctl_pkg::WARN_ALT_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic signed [15:0] conc_i,
    input wire logic signed [15:0] setpoint_i,
    input wire logic signed [15:0] suppress_thr_i,
    input wire logic alarm_delay_en_i,
    input wire logic menu_escape_key_i,
    input wire logic next_key_i,
    input wire logic set_key_i,
    input wire logic fault_i,
    input wire logic [7:0] fault_code_i,
    input wire logic loop_ok_i,
    input wire logic over_temp_i,
    input wire logic inhibit_i,
    input wire logic [15:0] inhibit_code_i,
    input wire logic alarm_test_i,
    input wire logic test_out_on_i,
    output logic power_lamp_o,
    output logic alarm_lamp_o,
    output logic fault_lamp_o,
    output logic gas_alarm_o,
    output logic cannot_detect_o,
    output logic firmware_checksum_display_o,
    output logic [2:0] mode_o,
    output logic [1:0] menu_item_o,
    output logic [2:0] disp_kind_o,
    output logic signed [15:0] disp_value_o,
    output logic [15:0] loop_code_o
);
    // ------------------------------------------------------------------
    // Key synchronisers and press detection
    // ------------------------------------------------------------------
    logic [2:0] key_s1_r, key_s2_r, key_s3_r;
    logic esc_press, next_press, set_press;

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            key_s1_r <= '0;
            key_s2_r <= '0;
            key_s3_r <= '0;
        end else begin
            key_s1_r <= {set_key_i, next_key_i, menu_escape_key_i};
            key_s2_r <= key_s1_r;
            key_s3_r <= key_s2_r;
        end
    end
    assign esc_press = key_s2_r[0] && !key_s3_r[0];
    assign next_press = key_s2_r[1] && !key_s3_r[1];
    assign set_press = key_s2_r[2] && !key_s3_r[2];

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    gas_ctl_pkg::mode_t state_r, state_nxt;
    gas_ctl_pkg::item_t item_r, item_nxt;
    gas_ctl_pkg::zero_res_t zres_r, zres_nxt;
    logic signed [15:0] zero_ofs_r, zero_ofs_nxt;
    logic cant_r, cant_nxt;
    logic alarm_r, alarm_nxt;
    logic alt_r, alt_nxt;
    logic init_done, user_done, dly_done, alt_done;
    logic abnormal, above, zero_view, neg_zero;
    logic signed [16:0] corr;
    logic signed [15:0] shown;
    logic [31:0] prop_wide;
    logic [15:0] prop_code, loop_nxt;
    gas_ctl_pkg::disp_t kind_nxt;
    logic signed [15:0] value_nxt;

    assign abnormal = fault_i || !loop_ok_i;
    assign zero_view = (state_r == gas_ctl_pkg::ST_USER) && (item_r == gas_ctl_pkg::ITEM_ZERO);

    tick_timer #(.W(gas_ctl_pkg::TW)) u_init_tmr (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .run_i(state_r == gas_ctl_pkg::ST_INIT), .limit_i(INIT_CLEAR_CYC), .done_o(init_done));
    tick_timer #(.W(gas_ctl_pkg::TW)) u_user_tmr (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .run_i(state_r == gas_ctl_pkg::ST_USER), .limit_i(USER_TIMEOUT_CYC),
        .done_o(user_done));
    tick_timer #(.W(gas_ctl_pkg::TW)) u_dly_tmr (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .run_i(above && (state_r == gas_ctl_pkg::ST_DETECT)), .limit_i(ALARM_DELAY_CYC),
        .done_o(dly_done));
    tick_timer #(.W(gas_ctl_pkg::TW)) u_alt_tmr (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
        .run_i(over_temp_i && !alt_done), .limit_i(WARN_ALT_CYC), .done_o(alt_done));

    // ------------------------------------------------------------------
    // Reading correction and suppression
    // ------------------------------------------------------------------
    always_comb begin
        corr = 17'(conc_i) - 17'(zero_ofs_r);
        neg_zero = 1'b0;
        shown = corr[15:0];
        if (!zero_view) begin
            if (corr >= 0 && corr < 17'(suppress_thr_i)) begin
                shown = '0;
            end else if (corr < 0 && corr >= -17'(gas_ctl_pkg::NEG_LIMIT)) begin
                shown = '0;
            end else if (corr < -17'(gas_ctl_pkg::NEG_LIMIT)) begin
                shown = '0;
                neg_zero = 1'b1;
            end
        end
        above = !neg_zero && (corr >= 17'(setpoint_i));
    end

    // ------------------------------------------------------------------
    // Mode sequencing, menu and alarms
    // ------------------------------------------------------------------
    always_comb begin
        state_nxt = state_r;
        item_nxt = item_r;
        zres_nxt = zres_r;
        zero_ofs_nxt = zero_ofs_r;
        cant_nxt = cant_r;
        alt_nxt = over_temp_i ? (alt_r ^ alt_done) : 1'b0;
        case (state_r)
            gas_ctl_pkg::ST_INIT: begin
                if (init_done) begin
                    state_nxt = gas_ctl_pkg::ST_DETECT;
                end
            end
            gas_ctl_pkg::ST_DETECT: begin
                if (esc_press) begin
                    state_nxt = gas_ctl_pkg::ST_USER;
                    item_nxt = gas_ctl_pkg::ITEM_VERSION;
                    zres_nxt = gas_ctl_pkg::ZR_NONE;
                end
            end
            gas_ctl_pkg::ST_USER: begin
                if (esc_press || user_done) begin
                    state_nxt = gas_ctl_pkg::ST_DETECT;
                end else if (next_press) begin
                    item_nxt = gas_ctl_pkg::item_t'(item_r + 2'h1);
                    zres_nxt = gas_ctl_pkg::ZR_NONE;
                end else if (set_press) begin
                    if (item_r == gas_ctl_pkg::ITEM_MAINT) begin
                        state_nxt = gas_ctl_pkg::ST_MAINT;
                    end else if (item_r == gas_ctl_pkg::ITEM_ZERO) begin
                        if (corr <= 17'(gas_ctl_pkg::ZERO_LIMIT) &&
                            corr >= -17'(gas_ctl_pkg::ZERO_LIMIT)) begin
                            zero_ofs_nxt = conc_i;
                            zres_nxt = gas_ctl_pkg::ZR_PASS;
                            cant_nxt = 1'b0;
                        end else begin
                            zres_nxt = gas_ctl_pkg::ZR_FAIL;
                        end
                    end
                end
            end
            gas_ctl_pkg::ST_MAINT: begin
                if (esc_press) begin
                    state_nxt = gas_ctl_pkg::ST_DETECT;
                end
            end
            default: begin
                if (!abnormal) begin
                    state_nxt = gas_ctl_pkg::ST_INIT;
                end
            end
        endcase
        if (abnormal) begin
            state_nxt = gas_ctl_pkg::ST_FAULT;
        end
        if (neg_zero) begin
            cant_nxt = 1'b1;
        end
        alarm_nxt = (state_nxt == gas_ctl_pkg::ST_DETECT) && above && !cant_nxt &&
                    (!alarm_delay_en_i || dly_done || alarm_r);
    end

    // ------------------------------------------------------------------
    // Loop output selection and display
    // ------------------------------------------------------------------
    always_comb begin
        prop_wide = 32'(shown[15] ? 16'h0000 : shown) * 32'(gas_ctl_pkg::LOOP_SPAN)
                    / 32'(gas_ctl_pkg::FULL_SCALE);
        prop_code = gas_ctl_pkg::LOOP_4MA + prop_wide[15:0];
        if (prop_code > gas_ctl_pkg::LOOP_OVER || shown > gas_ctl_pkg::FULL_SCALE) begin
            prop_code = gas_ctl_pkg::LOOP_OVER;
        end
        case (state_r)
            gas_ctl_pkg::ST_FAULT: loop_nxt = gas_ctl_pkg::LOOP_FAULT;
            gas_ctl_pkg::ST_INIT, gas_ctl_pkg::ST_MAINT: loop_nxt = gas_ctl_pkg::LOOP_4MA;
            default: begin
                if (inhibit_i) begin
                    loop_nxt = inhibit_code_i;
                end else if (alarm_test_i) begin
                    loop_nxt = test_out_on_i ? prop_code : gas_ctl_pkg::LOOP_4MA;
                end else begin
                    loop_nxt = prop_code;
                end
            end
        endcase
        kind_nxt = gas_ctl_pkg::DK_CONC;
        value_nxt = shown;
        if (state_r == gas_ctl_pkg::ST_FAULT) begin
            kind_nxt = gas_ctl_pkg::DK_ERROR;
            value_nxt = 16'(loop_ok_i ? fault_code_i : gas_ctl_pkg::ERR_LOOP);
        end else if (state_r == gas_ctl_pkg::ST_USER) begin
            kind_nxt = gas_ctl_pkg::DK_MENU;
            value_nxt = 16'(item_r);
            if (item_r == gas_ctl_pkg::ITEM_ZERO && zres_r == gas_ctl_pkg::ZR_PASS) begin
                kind_nxt = gas_ctl_pkg::DK_PASS;
            end else if (item_r == gas_ctl_pkg::ITEM_ZERO && zres_r == gas_ctl_pkg::ZR_FAIL) begin
                kind_nxt = gas_ctl_pkg::DK_FAIL;
            end else if (item_r == gas_ctl_pkg::ITEM_SETTINGS) begin
                kind_nxt = gas_ctl_pkg::DK_SETTINGS;
                value_nxt = setpoint_i;
            end
        end else if (neg_zero) begin
            kind_nxt = gas_ctl_pkg::DK_NEG_ZERO;
        end else if (alt_r) begin
            kind_nxt = gas_ctl_pkg::DK_WARN;
            value_nxt = 16'(gas_ctl_pkg::WARN_TEMP);
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            state_r <= gas_ctl_pkg::ST_INIT;
            item_r <= gas_ctl_pkg::ITEM_VERSION;
            zres_r <= gas_ctl_pkg::ZR_NONE;
            zero_ofs_r <= '0;
            cant_r <= 1'b0;
            alarm_r <= 1'b0;
            alt_r <= 1'b0;
            power_lamp_o <= 1'b0;
            alarm_lamp_o <= 1'b0;
            fault_lamp_o <= 1'b0;
            gas_alarm_o <= 1'b0;
            cannot_detect_o <= 1'b0;
            firmware_checksum_display_o <= 1'b0;
            mode_o <= '0;
            menu_item_o <= '0;
            disp_kind_o <= '0;
            disp_value_o <= '0;
            loop_code_o <= gas_ctl_pkg::LOOP_4MA;
        end else begin
            state_r <= state_nxt;
            item_r <= item_nxt;
            zres_r <= zres_nxt;
            zero_ofs_r <= zero_ofs_nxt;
            cant_r <= cant_nxt;
            alarm_r <= alarm_nxt;
            alt_r <= alt_nxt;
            power_lamp_o <= 1'b1;
            alarm_lamp_o <= alarm_nxt;
            fault_lamp_o <= (state_nxt == gas_ctl_pkg::ST_FAULT);
            gas_alarm_o <= alarm_nxt;
            cannot_detect_o <= cant_nxt;
            firmware_checksum_display_o <= (state_nxt == gas_ctl_pkg::ST_USER) &&
                                           (item_nxt == gas_ctl_pkg::ITEM_VERSION);
            mode_o <= 3'(state_nxt);
            menu_item_o <= 2'(item_nxt);
            disp_kind_o <= 3'(kind_nxt);
            disp_value_o <= value_nxt;
            loop_code_o <= loop_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_fault_gone;
        state_r == gas_ctl_pkg::ST_FAULT && !abnormal;
    endsequence
    property p_init_exit;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        state_r == gas_ctl_pkg::ST_INIT && init_done && !abnormal |=>
        state_r == gas_ctl_pkg::ST_DETECT;
    endproperty
    a_init_exit: assert property (p_init_exit) else $error("init clear did not end");
    property p_alarm_only_detect;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        gas_alarm_o |-> state_r == gas_ctl_pkg::ST_DETECT;
    endproperty
    a_alarm_only_detect: assert property (p_alarm_only_detect) else $error("alarm outside detect");
    property p_user_leave;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        state_r == gas_ctl_pkg::ST_USER && (esc_press || user_done) && !abnormal |=>
        state_r == gas_ctl_pkg::ST_DETECT;
    endproperty
    a_user_leave: assert property (p_user_leave) else $error("user mode not left");
    property p_delay;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        $rose(gas_alarm_o) |-> $past(above) && (!$past(alarm_delay_en_i) || $past(dly_done));
    endproperty
    a_delay: assert property (p_delay) else $error("alarm rose without delay");
    property p_self_clear;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        !above |=> !gas_alarm_o;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("alarm did not clear");
    property p_lamp;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        alarm_lamp_o == gas_alarm_o;
    endproperty
    a_lamp: assert property (p_lamp) else $error("alarm lamp mismatch");
    property p_power;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        $past(rstn_i) |-> power_lamp_o;
    endproperty
    a_power: assert property (p_power) else $error("power lamp off");
    property p_fault_lamp;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        fault_lamp_o == (state_r == gas_ctl_pkg::ST_FAULT);
    endproperty
    a_fault_lamp: assert property (p_fault_lamp) else $error("fault lamp mismatch");
    property p_fault_restart;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        s_fault_gone |=> state_r == gas_ctl_pkg::ST_INIT ##1 !gas_alarm_o;
    endproperty
    a_fault_restart: assert property (p_fault_restart) else $error("no restart");
    property p_fault_loop;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        state_r == gas_ctl_pkg::ST_FAULT |=> loop_code_o == gas_ctl_pkg::LOOP_FAULT;
    endproperty
    a_fault_loop: assert property (p_fault_loop) else $error("fault loop code wrong");
    property p_clamp;
        @(posedge sys_clk_i) disable iff (!rstn_i)
        state_r != gas_ctl_pkg::ST_FAULT && !inhibit_i |=> loop_code_o <= gas_ctl_pkg::LOOP_OVER;
    endproperty
    a_clamp: assert property (p_clamp) else $error("loop above 20.5 mA");
endmodule // gas_alarm_mode_controller

// [pkg/gas_ctl_pkg.sv]
// Constants shared by the gas alarm mode controller.
package gas_ctl_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam longint unsigned CLK_HZ = 64'h0000_0000_05f5_e100;
    localparam longint unsigned INIT_CLEAR_S = 64'h19;
    localparam longint unsigned ALARM_DELAY_S = 64'h2;
    localparam longint unsigned USER_TIMEOUT_H = 64'ha;
    localparam longint unsigned SEC_PER_HOUR = 64'he10;
    localparam longint unsigned WARN_ALT_S = 64'h1;
    localparam int TW = 42;
    localparam logic [TW-1:0] INIT_CLEAR_CYC = TW'(INIT_CLEAR_S * CLK_HZ);
    localparam logic [TW-1:0] ALARM_DELAY_CYC = TW'(ALARM_DELAY_S * CLK_HZ);
    localparam logic [TW-1:0] USER_TIMEOUT_CYC = TW'(USER_TIMEOUT_H * SEC_PER_HOUR * CLK_HZ);
    localparam logic [TW-1:0] WARN_ALT_CYC = TW'(WARN_ALT_S * CLK_HZ);
    // ------------------------------------------------------------------
    // Concentration scale, in thousandths of full scale
    // ------------------------------------------------------------------
    localparam int CW = 16;
    localparam logic signed [CW-1:0] FULL_SCALE = 16'sh03e8;
    localparam logic signed [CW-1:0] SUPPRESS_DEF = 16'sh003c;
    localparam logic signed [CW-1:0] NEG_LIMIT = 16'sh0064;
    localparam logic signed [CW-1:0] ZERO_LIMIT = 16'sh0064;
    // ------------------------------------------------------------------
    // Loop output codes, in microamps
    // ------------------------------------------------------------------
    localparam logic [15:0] LOOP_4MA = 16'h0fa0;
    localparam logic [15:0] LOOP_SPAN = 16'h3e80;
    localparam logic [15:0] LOOP_FAULT = 16'h01f4;
    localparam logic [15:0] LOOP_OVER = 16'h5014;
    // ------------------------------------------------------------------
    // Modes, menu items and display
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {ST_INIT, ST_DETECT, ST_USER, ST_MAINT, ST_FAULT} mode_t;
    typedef enum logic [1:0] {ITEM_VERSION, ITEM_ZERO, ITEM_SETTINGS, ITEM_MAINT} item_t;
    typedef enum logic [2:0] {DK_CONC, DK_MENU, DK_PASS, DK_FAIL, DK_ERROR, DK_NEG_ZERO,
                              DK_WARN, DK_SETTINGS} disp_t;
    typedef enum logic [1:0] {ZR_NONE, ZR_PASS, ZR_FAIL} zero_res_t;
    localparam logic [7:0] ERR_LOOP = 8'h09;
    localparam logic [7:0] WARN_TEMP = 8'h1b;
endpackage

// [logic/tick_timer.sv]
// Restartable cycle counter with a registered done flag.
`timescale 1ns/1ns
module tick_timer #(
    parameter int W = 42
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic run_i,
    input wire logic [W-1:0] limit_i,
    output logic done_o
);
    logic [W-1:0] count_r;
    logic [W-1:0] count_nxt;
    logic done_nxt;

    // Counts while run is high, holds at the limit, restarts when run drops.
    always_comb begin
        count_nxt = '0;
        if (run_i) begin
            count_nxt = (count_r == limit_i) ? count_r : count_r + W'(1);
        end
        done_nxt = run_i && (count_nxt == limit_i);
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            count_r <= '0;
            done_o <= 1'b0;
        end else begin
            count_r <= count_nxt;
            done_o <= done_nxt;
        end
    end
endmodule // tick_timer

// [dv/loop_monitor.sv]
// Central monitoring side of the current loop: classifies the received loop code.
`timescale 1ns/1ns
module loop_monitor (
    input wire logic sys_clk_i,
    input wire logic [15:0] loop_code_i,
    output logic [1:0] loop_class_o
);
    logic [1:0] class_nxt;
    // Class 0 is live reading, 1 is a fault current, 2 is an over-scale current.
    always_comb begin
        class_nxt = 2'h0;
        if (loop_code_i < 16'h0fa0) begin
            class_nxt = 2'h1;
        end else if (loop_code_i > 16'h4e20) begin
            class_nxt = 2'h2;
        end
    end
    always_ff @(posedge sys_clk_i) begin
        loop_class_o <= class_nxt;
    end
endmodule // loop_monitor

// [dv/tb.sv]
// Self-checking testbench of the gas alarm mode controller.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module tb;
    logic sys_clk_i = 0, rstn_i = 0, dly = 0, esc = 0, nxt = 0, setk = 0, flt = 0, lok = 1;
    logic otmp = 0, inh = 0, atst = 0, tout = 0, plamp, alamp, flamp, galm, cdet, fwsum;
    logic signed [15:0] conc = 0, setp = 16'sh0190, thr = 16'sh003c, dval;
    logic [7:0] fcode = 8'h33;
    logic [15:0] icode = 16'h0fa0, lcode;
    logic [2:0] mode, dkind;
    logic [1:0] item, lclass;
    int n_errors = 0, cmp_count = 0, k;
    always #5 sys_clk_i = ~sys_clk_i;
    gas_alarm_mode_controller #(.INIT_CLEAR_CYC(42'd20), .ALARM_DELAY_CYC(42'd5),
        .USER_TIMEOUT_CYC(42'd30), .WARN_ALT_CYC(42'd4)) i_gas_alarm_mode_controller (
        .sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .conc_i(conc), .setpoint_i(setp),
        .suppress_thr_i(thr), .alarm_delay_en_i(dly), .menu_escape_key_i(esc),
        .next_key_i(nxt), .set_key_i(setk), .fault_i(flt), .fault_code_i(fcode),
        .loop_ok_i(lok), .over_temp_i(otmp), .inhibit_i(inh), .inhibit_code_i(icode),
        .alarm_test_i(atst), .test_out_on_i(tout), .power_lamp_o(plamp),
        .alarm_lamp_o(alamp), .fault_lamp_o(flamp), .gas_alarm_o(galm),
        .cannot_detect_o(cdet), .firmware_checksum_display_o(fwsum), .mode_o(mode),
        .menu_item_o(item), .disp_kind_o(dkind), .disp_value_o(dval), .loop_code_o(lcode));
    loop_monitor i_loop_monitor (.sys_clk_i(sys_clk_i), .loop_code_i(lcode),
        .loop_class_o(lclass));
    // ------------------------------------------------------------------
    // Tasks and expectation functions
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic press(ref logic key);
        key = 1;
        cyc(3);
        key = 0;
        cyc(3);
    endtask
    task automatic wait_mode(input logic [2:0] m, input int lim);
        for (int i = 0; i < lim && mode !== m; i++) cyc(1);
        `CHK("mode", m, mode)
        if (mode !== m) report_and_stop();
    endtask
    function automatic logic [15:0] exp_loop(input int c, input bit sup);
        int s;
        s = (sup && c > 0 && c < thr) ? 0 : c;
        return (s > 1000) ? 16'h5014 : 16'(4000 + s * 16);
    endfunction
    initial begin
        k = $urandom(16);
        setp = 16'(200 + $urandom % 500);
        cyc(4);
        `CHK("loop_rst", 16'h0fa0, lcode)
        rstn_i = 1;
        conc = 16'sh03e8;
        cyc(15);
        `CHK("plamp", 1'b1, plamp)
        `CHK("init_mode", 3'h0, mode)
        `CHK("init_alarm", 1'b0, galm)
        `CHK("init_loop", 16'h0fa0, lcode)
        conc = 0;
        wait_mode(3'h1, 20);
        for (k = 0; k < 40; k++) begin
            conc = (k == 0) ? setp : (k == 1) ? setp - 1 : (k == 2) ? 16'sh03e9 :
                   (k == 3) ? thr - 1 : (k == 4) ? thr : 16'($urandom % 1100);
            cyc(4);
            `CHK("alarm", conc >= setp, galm)
            `CHK("lamp", conc >= setp, alamp)
            `CHK("loop", exp_loop(conc, 1), lcode)
            `CHK("class", (conc > 1000) ? 2'h2 : 2'h0, lclass)
        end
        conc = 0;
        dly = 1;
        cyc(3);
        conc = setp;
        cyc(4);
        conc = 0;
        cyc(1);
        conc = setp;
        cyc(4);
        `CHK("delay_restart", 1'b0, galm)
        for (k = 0; k < 10 && galm !== 1; k++) cyc(1);
        `CHK("delay_alarm", 1'b1, galm)
        if (galm !== 1'b1) report_and_stop();
        otmp = 1;
        for (k = 0; k < 12 && dkind !== 3'h6; k++) cyc(1);
        `CHK("warn", 3'h6, dkind)
        if (dkind !== 3'h6) report_and_stop();
        `CHK("warn_flamp", 1'b0, flamp)
        `CHK("warn_loop", exp_loop(setp, 1), lcode)
        otmp = 0;
        inh = 1;
        icode = 16'(4000 + $urandom % 16000);
        cyc(3);
        `CHK("inhibit", icode, lcode)
        inh = 0;
        atst = 1;
        tout = 1;
        cyc(3);
        `CHK("test_on", exp_loop(setp, 1), lcode)
        tout = 0;
        cyc(3);
        `CHK("test_off", 16'h0fa0, lcode)
        atst = 0;
        press(esc);
        `CHK("user", 3'h2, mode)
        `CHK("leave_alarm", 1'b0, galm)
        `CHK("fwsum", 1'b1, fwsum)
        for (k = 1; k < 4; k++) begin
            press(nxt);
            `CHK("item", 2'(k), item)
            `CHK("menu_kind", (k == 2) ? 3'h7 : 3'h1, dkind)
            if (k == 2) `CHK("settings", setp, dval)
        end
        press(setk);
        `CHK("maint", 3'h3, mode)
        `CHK("maint_loop", 16'h0fa0, lcode)
        press(esc);
        `CHK("escape", 3'h1, mode)
        press(esc);
        press(nxt);
        conc = 16'sh001e;
        cyc(3);
        `CHK("no_suppress", exp_loop(30, 0), lcode)
        conc = 16'sh012c;
        press(setk);
        `CHK("zero_fail", 3'h3, dkind)
        `CHK("fail_item", 2'h1, item)
        conc = 0;
        press(setk);
        `CHK("zero_pass", 3'h2, dkind)
        wait_mode(3'h1, 60);
        conc = -16'sh0096;
        cyc(3);
        `CHK("neg_flag", 1'b1, cdet)
        `CHK("neg_disp", 3'h5, dkind)
        conc = 0;
        lok = 0;
        cyc(4);
        `CHK("loop_err", 16'sh0009, dval)
        `CHK("fault_class", 2'h1, lclass)
        lok = 1;
        flt = 1;
        cyc(3);
        `CHK("fault_mode", 3'h4, mode)
        `CHK("fault_lamp", 1'b1, flamp)
        `CHK("fault_code", {8'h00, fcode}, dval)
        `CHK("fault_loop", 16'h01f4, lcode)
        flt = 0;
        cyc(3);
        `CHK("restart", 3'h0, mode)
        wait_mode(3'h1, 40);
        report_and_stop();
    end
endmodule // tb
